/* rtl/awt_chan_seq.sv */
// Purpose: Channel counter of the multi-channel sequencer with wrap to channel 0.
// Assumes: Start and conversion-done pulses come from logic on the same clock.
// Notes: A wrap field of zero keeps the counter on channel 0 once it gets there; a nonzero start_chan counts up through 15 first.
`timescale 1ns/1ps
module awt_chan_seq
    import awt_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic seq_start,
    input wire logic [CHAN_W-1:0] start_chan,
    input wire logic conv_done,
    input wire logic multi_channel_mode,
    input wire logic [CHAN_W-1:0] wrap_field,
    output logic [CHAN_W-1:0] cur_chan
);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur_chan <= CHAN_ZERO;
        end else if (seq_start) begin
            cur_chan <= start_chan;
        end else if (conv_done && multi_channel_mode) begin
            if (cur_chan == wrap_field) begin
                cur_chan <= CHAN_ZERO;
            end else begin
                cur_chan <= CHAN_W'(cur_chan + 4'h1);
            end
        end
    end

    property p_wrap_to_zero;
        @(posedge clk) disable iff (!rstn)
        (conv_done && multi_channel_mode && !seq_start && cur_chan == wrap_field)
            |=> (cur_chan == CHAN_ZERO);
    endproperty
    a_wrap_to_zero: assert property (p_wrap_to_zero)
        else $error("No wrap to channel 0.");

    property p_step_up;
        @(posedge clk) disable iff (!rstn)
        (conv_done && multi_channel_mode && !seq_start && cur_chan != wrap_field)
            |=> (cur_chan == CHAN_W'($past(cur_chan) + 4'h1));
    endproperty
    a_step_up: assert property (p_step_up) else $error("Channel did not advance.");

    property p_wrap_seen;
        @(posedge clk) disable iff (!rstn)
        conv_done && multi_channel_mode && cur_chan == wrap_field && cur_chan != CHAN_ZERO;
    endproperty
    c_wrap_seen: cover property (p_wrap_seen);

endmodule // awt_chan_seq

/* rtl/awt_pkg.sv */
// Purpose: Shared constants and types for the converter wrap and trigger select block.
// Assumes: 32-bit AHB-Lite data, one register per aligned word.
// Notes: Register byte address is four times the register index.
package awt_pkg;

    localparam int unsigned NUM_CHAN = 16;
    localparam int unsigned NUM_DED = 4;
    localparam int unsigned CHAN_W = 4;

    localparam logic [29:0] IDX_WRAP = 30'h0;
    localparam logic [29:0] IDX_TRIG = 30'h1;
    localparam logic [31:0] ADDR_WRAP = {IDX_WRAP, 2'b00};
    localparam logic [31:0] ADDR_TRIG = {IDX_TRIG, 2'b00};

    localparam int unsigned WRAP_LSB = 0;
    localparam int unsigned CHAN_LSB = 0;
    localparam int unsigned SEL_BIT = 7;

    localparam logic [3:0] WRAP_RST = 4'hF;
    localparam logic [3:0] CHAN_RST = 4'h0;
    localparam logic SEL_RST = 1'b0;
    localparam logic [3:0] CHAN_ZERO = 4'h0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic sel;
        logic [CHAN_W-1:0] chan;
        logic [CHAN_W-1:0] wrap;
    } awt_cfg_s;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b11
    } awt_bus_e;

endpackage

/* rtl/awt_top.sv */
// Purpose: Wrap channel and trigger source configuration of a converter sequencer.
// Assumes: One AHB-Lite slave; hready is this slave's hreadyout.
// Notes: Zero wait states; read data come from a register.
`timescale 1ns/1ps
module awt_top
    import awt_pkg::*;
#(
    parameter bit HAS_DED_TRIG = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic multi_channel_mode,
    input wire logic ext_trigger_enable,
    input wire logic seq_start,
    input wire logic [CHAN_W-1:0] start_chan,
    input wire logic conv_done,
    input wire logic [NUM_CHAN-1:0] an_pins,
    input wire logic [NUM_DED-1:0] dedicated_trigger_inputs,
    output logic seq_abort,
    output logic [CHAN_W-1:0] cur_chan,
    output logic trig_level,
    output logic [NUM_CHAN-1:0] dig_in_enable
);

    awt_bus_e bus_state;
    awt_bus_e next_bus_state;
    logic [31:0] addr_q;
    awt_cfg_s cfg;
    awt_cfg_s next_cfg;
    logic take;
    logic wr_hit;
    logic [31:0] rd_value;

    // Only whole-word single transfers are expected, so hsize is not decoded.
    assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wr_hit = (bus_state == BUS_WRITE) && (addr_q == ADDR_WRAP || addr_q == ADDR_TRIG);

    always_comb begin
        next_bus_state = bus_state;
        if (hready) begin
            if (take) begin
                next_bus_state = hwrite ? BUS_WRITE : BUS_READ;
            end else begin
                next_bus_state = BUS_IDLE;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= BUS_IDLE;
            addr_q <= 32'h0000_0000;
        end else begin
            bus_state <= next_bus_state;
            if (take) begin
                addr_q <= haddr;
            end
        end
    end

    // Writes are taken whatever the converter is doing.
    always_comb begin
        next_cfg = cfg;
        if (bus_state == BUS_WRITE && addr_q == ADDR_WRAP) begin
            next_cfg.wrap = hwdata[WRAP_LSB +: CHAN_W];
        end
        if (bus_state == BUS_WRITE && addr_q == ADDR_TRIG) begin
            next_cfg.sel = hwdata[SEL_BIT];
            next_cfg.chan = hwdata[CHAN_LSB +: CHAN_W];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg.wrap <= WRAP_RST;
            cfg.sel <= SEL_RST;
            cfg.chan <= CHAN_RST;
        end else begin
            cfg <= next_cfg;
        end
    end

    // Reading from next_cfg forwards a write still in its data phase.
    always_comb begin
        rd_value = 32'h0000_0000;
        if (haddr == ADDR_WRAP) begin
            rd_value[WRAP_LSB +: CHAN_W] = next_cfg.wrap;
        end else if (haddr == ADDR_TRIG) begin
            rd_value[SEL_BIT] = next_cfg.sel;
            rd_value[CHAN_LSB +: CHAN_W] = next_cfg.chan;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= rd_value;
        end else if (hready) begin
            hrdata <= 32'h0000_0000;
        end
    end

    // The slave never stretches a transfer and never reports an error.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // The abort is a single pulse; this block has no way to start a sequence.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_abort <= 1'b0;
        end else begin
            seq_abort <= wr_hit;
        end
    end

    // A reserved wrap code of zero pins the counter at channel 0 once it reaches it; a start above 0 counts up through 15 first.
    awt_chan_seq u_chan_seq (
        .clk(hclk),
        .rstn(hresetn),
        .seq_start(seq_start),
        .start_chan(start_chan),
        .conv_done(conv_done),
        .multi_channel_mode(multi_channel_mode),
        .wrap_field(cfg.wrap),
        .cur_chan(cur_chan)
    );

    awt_trig_sel #(
        .HAS_DED_TRIG(HAS_DED_TRIG)
    ) u_trig_sel (
        .clk(hclk),
        .rstn(hresetn),
        .an_pins(an_pins),
        .dedicated_trigger_inputs(dedicated_trigger_inputs),
        .ext_trigger_enable(ext_trigger_enable),
        .cfg(cfg),
        .trig_level(trig_level),
        .dig_in_enable(dig_in_enable)
    );

    property p_abort_on_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_hit |=> seq_abort;
    endproperty
    a_abort_on_write: assert property (p_abort_on_write)
        else $error("Write did not abort.");

    property p_abort_only_write;
        @(posedge hclk) disable iff (!hresetn)
        seq_abort |-> $past(bus_state) == BUS_WRITE;
    endproperty
    a_abort_only_write: assert property (p_abort_only_write)
        else $error("Stray abort.");

    property p_abort_pulse;
        @(posedge hclk) disable iff (!hresetn)
        (seq_abort && bus_state != BUS_WRITE) |=> !seq_abort;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse)
        else $error("Abort held too long.");

    property p_wrap_read_upper;
        @(posedge hclk) disable iff (!hresetn)
        (bus_state == BUS_READ && addr_q == ADDR_WRAP) |-> (hrdata[31:CHAN_W] == '0);
    endproperty
    a_wrap_read_upper: assert property (p_wrap_read_upper)
        else $error("Wrap upper bits set.");

    property p_wrap_read_value;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr == ADDR_WRAP && bus_state != BUS_WRITE)
            |=> (hrdata[CHAN_W-1:0] == cfg.wrap);
    endproperty
    a_wrap_read_value: assert property (p_wrap_read_value)
        else $error("Wrap readback wrong.");

    property p_wrap_write;
        @(posedge hclk) disable iff (!hresetn)
        (bus_state == BUS_WRITE && addr_q == ADDR_WRAP)
            |=> (cfg.wrap == $past(hwdata[CHAN_W-1:0]));
    endproperty
    a_wrap_write: assert property (p_wrap_write)
        else $error("Wrap write lost.");

    property p_trig_write;
        @(posedge hclk) disable iff (!hresetn)
        (bus_state == BUS_WRITE && addr_q == ADDR_TRIG)
            |=> (cfg.sel == $past(hwdata[SEL_BIT]) && cfg.chan == $past(hwdata[CHAN_W-1:0]));
    endproperty
    a_trig_write: assert property (p_trig_write)
        else $error("Trigger write lost.");

    property p_trig_readback;
        @(posedge hclk) disable iff (!hresetn)
        (bus_state == BUS_WRITE && addr_q == ADDR_TRIG) ##1
            (take && !hwrite && haddr == ADDR_TRIG && bus_state != BUS_WRITE)
            |=> (hrdata[SEL_BIT] == cfg.sel && hrdata[6:CHAN_W] == '0);
    endproperty
    a_trig_readback: assert property (p_trig_readback)
        else $error("Trigger readback wrong.");

    property p_forward;
        @(posedge hclk) disable iff (!hresetn)
        (bus_state == BUS_WRITE && addr_q == ADDR_WRAP && take && !hwrite && haddr == ADDR_WRAP)
            |=> (hrdata[CHAN_W-1:0] == $past(hwdata[CHAN_W-1:0]));
    endproperty
    a_forward: assert property (p_forward)
        else $error("Read after write stale.");

    property p_okay;
        @(posedge hclk) disable iff (!hresetn)
        take |=> (hreadyout && !hresp) [*2];
    endproperty
    a_okay: assert property (p_okay)
        else $error("Slave not ready or error.");

    // Reads must leave both the configuration and the sequencer alone.
    property p_hrdata_idle;
        @(posedge hclk) disable iff (!hresetn)
        (bus_state != BUS_READ) |-> (hrdata == 32'h0000_0000);
    endproperty
    a_hrdata_idle: assert property (p_hrdata_idle)
        else $error("Read data outside a read.");

    property p_trig_read_value;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr == ADDR_TRIG && bus_state != BUS_WRITE)
            |=> (hrdata == {24'h00_0000, cfg.sel, 3'h0, cfg.chan});
    endproperty
    a_trig_read_value: assert property (p_trig_read_value)
        else $error("Trigger read value wrong.");

    property p_unmapped_read;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && haddr != ADDR_WRAP && haddr != ADDR_TRIG)
            |=> (hrdata == 32'h0000_0000);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("Unmapped read not zero.");

    property p_cfg_hold;
        @(posedge hclk) disable iff (!hresetn)
        (bus_state != BUS_WRITE) |=> $stable(cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("Config changed without a write.");

    property p_no_abort_unmapped;
        @(posedge hclk) disable iff (!hresetn)
        (bus_state == BUS_WRITE && !wr_hit) |=> !seq_abort;
    endproperty
    a_no_abort_unmapped: assert property (p_no_abort_unmapped)
        else $error("Unmapped write aborted.");

    property p_no_abort_read;
        @(posedge hclk) disable iff (!hresetn)
        (bus_state == BUS_READ) |=> !seq_abort;
    endproperty
    a_no_abort_read: assert property (p_no_abort_read)
        else $error("Read aborted the sequence.");

    property p_unmapped_write_seen;
        @(posedge hclk) disable iff (!hresetn)
        (bus_state == BUS_WRITE) && !wr_hit;
    endproperty
    c_unmapped_write_seen: cover property (p_unmapped_write_seen);

    property p_write_abort_seen;
        @(posedge hclk) disable iff (!hresetn)
        wr_hit ##1 seq_abort;
    endproperty
    c_write_abort_seen: cover property (p_write_abort_seen);

    property p_read_after_write;
        @(posedge hclk) disable iff (!hresetn)
        (bus_state == BUS_WRITE) && take && !hwrite;
    endproperty
    c_read_after_write: cover property (p_read_after_write);

endmodule // awt_top

/* rtl/awt_trig_sel.sv */
// Purpose: Synchronises trigger pins and picks the external trigger source.
// Assumes: Analog channel digital levels and dedicated inputs are asynchronous pins.
// Notes: Reserved dedicated codes give a trigger level of zero.
`timescale 1ns/1ps
module awt_trig_sel
    import awt_pkg::*;
#(
    parameter bit HAS_DED_TRIG = 1'b1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [NUM_CHAN-1:0] an_pins,
    input wire logic [NUM_DED-1:0] dedicated_trigger_inputs,
    input wire logic ext_trigger_enable,
    input wire awt_cfg_s cfg,
    output logic trig_level,
    output logic [NUM_CHAN-1:0] dig_in_enable
);

    localparam int unsigned NPIN = NUM_CHAN + NUM_DED;

    logic [NPIN-1:0] pin_q1;
    logic [NPIN-1:0] pin_q2;
    logic ded_use;
    logic ded_legal;
    logic an_pick;
    logic ded_pick;

    // Each pin passes two flops before the mux sees it.
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                pin_q1[i] <= 1'b0;
                pin_q2[i] <= 1'b0;
            end else begin
                pin_q1[i] <= (i < NUM_CHAN) ? an_pins[i % NUM_CHAN]
                        : dedicated_trigger_inputs[i % NUM_DED];
                pin_q2[i] <= pin_q1[i];
            end
        end
    end

    assign ded_use = HAS_DED_TRIG && cfg.sel;
    assign ded_legal = (cfg.chan[3:2] == 2'b00);
    assign an_pick = pin_q2[cfg.chan];
    assign ded_pick = pin_q2[NUM_CHAN + int'(cfg.chan[1:0])];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trig_level <= 1'b0;
            dig_in_enable <= '0;
        end else if (!ext_trigger_enable) begin
            trig_level <= 1'b0;
            dig_in_enable <= '0;
        end else if (ded_use) begin
            trig_level <= ded_legal && ded_pick;
            dig_in_enable <= '0;
        end else begin
            trig_level <= an_pick;
            dig_in_enable <= NUM_CHAN'(1) << cfg.chan;
        end
    end

    property p_analog_pick;
        @(posedge clk) disable iff (!rstn)
        (ext_trigger_enable && !ded_use) |=> (trig_level == $past(an_pick));
    endproperty
    a_analog_pick: assert property (p_analog_pick) else $error("Wrong analog trigger.");

    property p_ded_pick;
        @(posedge clk) disable iff (!rstn)
        (ext_trigger_enable && ded_use && ded_legal) |=> (trig_level == $past(ded_pick));
    endproperty
    a_ded_pick: assert property (p_ded_pick) else $error("Wrong dedicated trigger.");

    property p_sel_ignored;
        @(posedge clk) disable iff (!rstn)
        (ext_trigger_enable && cfg.sel && !HAS_DED_TRIG) |=> (trig_level == $past(an_pick));
    endproperty
    a_sel_ignored: assert property (p_sel_ignored)
        else $error("Select bit not ignored.");

    property p_disabled;
        @(posedge clk) disable iff (!rstn)
        !ext_trigger_enable |=> (trig_level == 1'b0 && dig_in_enable == '0);
    endproperty
    a_disabled: assert property (p_disabled) else $error("Trigger active while off.");

    property p_buf_enable;
        @(posedge clk) disable iff (!rstn)
        (ext_trigger_enable && !ded_use)
            |=> ($onehot(dig_in_enable) && dig_in_enable[$past(cfg.chan)]);
    endproperty
    a_buf_enable: assert property (p_buf_enable)
        else $error("Wrong input buffer enabled.");

    property p_ded_seen;
        @(posedge clk) disable iff (!rstn)
        ext_trigger_enable && ded_use && ded_legal;
    endproperty
    c_ded_seen: cover property (p_ded_seen);

endmodule // awt_trig_sel

/* sim/awt_pin_model.sv */
// Purpose: Far-side model of the analog channel pins and dedicated trigger inputs.
// Assumes: The pins are plain levels that never float.
// Notes: Only one source is high at a time unless all_on is set, so a wrong pick reads low.
`timescale 1ns/1ps
module awt_pin_model
    import awt_pkg::*;
(
    input wire logic [4:0] src,
    input wire logic all_on,
    output logic [NUM_CHAN-1:0] an_pins,
    output logic [NUM_DED-1:0] dedicated_trigger_inputs
);
    always_comb begin
        an_pins = 16'h0000;
        dedicated_trigger_inputs = 4'h0;
        if (all_on) begin
            an_pins = 16'hFFFF;
            dedicated_trigger_inputs = 4'hF;
        end else if (src < 5'h10) begin
            an_pins[src[3:0]] = 1'b1;
        end else if (src < 5'h14) begin
            dedicated_trigger_inputs[src[1:0]] = 1'b1;
        end
    end
endmodule // awt_pin_model

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the wrap and trigger select block.
// Assumes: Zero wait states are not relied on; every wait is bounded.
// Notes: A second instance without dedicated inputs shares the bus and pins.
`timescale 1ns/1ps
module tb_top
    import awt_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hreadyout2, hresp, hresp2;
    logic [31:0] haddr, hwdata, hrdata, hrdata2;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic multi_channel_mode, ext_trigger_enable, seq_start, conv_done, all_on;
    logic seq_abort, seq_abort2, trig_level, trig_level2;
    logic [3:0] start_chan, cur_chan, cur_chan2, ded;
    logic [4:0] src;
    logic [15:0] an_pins, die, die2;
    int bad_count, checks_done, abort_cnt, abort_cnt2;

    awt_top #(.HAS_DED_TRIG(1'b1)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .multi_channel_mode(multi_channel_mode), .ext_trigger_enable(ext_trigger_enable),
        .seq_start(seq_start), .start_chan(start_chan), .conv_done(conv_done),
        .an_pins(an_pins), .dedicated_trigger_inputs(ded), .seq_abort(seq_abort),
        .cur_chan(cur_chan), .trig_level(trig_level), .dig_in_enable(die));
    awt_top #(.HAS_DED_TRIG(1'b0)) dut_nd (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata2), .hreadyout(hreadyout2), .hresp(hresp2),
        .multi_channel_mode(multi_channel_mode), .ext_trigger_enable(ext_trigger_enable),
        .seq_start(seq_start), .start_chan(start_chan), .conv_done(conv_done),
        .an_pins(an_pins), .dedicated_trigger_inputs(ded), .seq_abort(seq_abort2),
        .cur_chan(cur_chan2), .trig_level(trig_level2), .dig_in_enable(die2));
    awt_pin_model pins (.src(src), .all_on(all_on), .an_pins(an_pins),
        .dedicated_trigger_inputs(ded));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // Counting pulses avoids guessing the exact cycle of the abort.
    always @(posedge hclk) begin
        if (seq_abort === 1'b1) begin
            abort_cnt++;
        end
        if (seq_abort2 === 1'b1) begin
            abort_cnt2++;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                check("hready", {31'h0, hreadyout}, 32'h1);
                finish_test();
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus_op(input logic [31:0] a, input logic w, input logic [31:0] d,
                          output logic [31:0] r, output logic [31:0] r2);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
        r2 = hrdata2;
        check("hresp", {31'h0, hresp}, 32'h0);
        check("hresp no ded", {31'h0, hresp2}, 32'h0);
        check("hreadyout no ded", {31'h0, hreadyout2}, 32'h1);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r, r2;
        bus_op(a, 1'b1, d, r, r2);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] exp2);
        logic [31:0] r, r2;
        bus_op(a, 1'b0, 32'h0, r, r2);
        check("read data", r, exp);
        check("read data no ded", r2, exp2);
    endtask

    task automatic wr_abort(input logic [31:0] a, input logic [31:0] d, input int exp);
        int c0;
        int c2;
        c0 = abort_cnt;
        c2 = abort_cnt2;
        wr(a, d);
        repeat (3) @(posedge hclk);
        check("abort pulses", abort_cnt - c0, exp);
        check("abort pulses no ded", abort_cnt2 - c2, exp);
    endtask

    task automatic seq_step(input logic st, input logic [3:0] ch, input logic [3:0] exp);
        seq_start <= st;
        conv_done <= ~st;
        start_chan <= ch;
        @(posedge hclk);
        seq_start <= 1'b0;
        conv_done <= 1'b0;
        @(posedge hclk);
        check("cur_chan", {28'h0, cur_chan}, {28'h0, exp});
        check("cur_chan no ded", {28'h0, cur_chan2}, {28'h0, exp});
    endtask

    task automatic test_regs();
        rd(ADDR_WRAP, {28'h0, WRAP_RST}, {28'h0, WRAP_RST});
        rd(ADDR_TRIG, 32'h0, 32'h0);
        wr_abort(ADDR_WRAP, 32'hFFFF_FFF5, 1);
        rd(ADDR_WRAP, 32'h5, 32'h5);
        wr_abort(ADDR_TRIG, 32'hFFFF_FFFF, 1);
        rd(ADDR_TRIG, 32'h8F, 32'h8F);
        // An unmapped write must neither store nor abort.
        wr_abort(32'h0000_0010, 32'hFFFF_FFFF, 0);
        rd(32'h0000_0010, 32'h0, 32'h0);
        wr(ADDR_WRAP, 32'h9);
        rd(ADDR_WRAP, 32'h9, 32'h9);
        wr(ADDR_TRIG, 32'h0000_0083);
        rd(ADDR_TRIG, 32'h83, 32'h83);
    endtask

    task automatic test_wrap();
        multi_channel_mode <= 1'b1;
        wr(ADDR_WRAP, 32'h3);
        seq_step(1'b1, 4'h2, 4'h2);
        seq_step(1'b0, 4'h0, 4'h3);
        seq_step(1'b0, 4'h0, 4'h0);
        seq_step(1'b0, 4'h0, 4'h1);
        // A write mid-sequence aborts but must leave the counter alone.
        wr_abort(ADDR_WRAP, 32'hF, 1);
        check("cur_chan after write", {28'h0, cur_chan}, 32'h1);
        check("cur_chan2 after write", {28'h0, cur_chan2}, 32'h1);
        seq_step(1'b1, 4'hE, 4'hE);
        seq_step(1'b0, 4'h0, 4'hF);
        seq_step(1'b0, 4'h0, 4'h0);
        multi_channel_mode <= 1'b0;
        seq_step(1'b0, 4'h0, 4'h0);
    endtask

    task automatic trig_case(input logic [7:0] cfg, input logic en, input logic [4:0] s,
                             input logic all);
        logic [15:0] an_die;
        logic an_lvl, ded_lvl, lvl;
        wr(ADDR_TRIG, {24'h0, cfg});
        ext_trigger_enable <= en;
        src <= s;
        all_on <= all;
        repeat (5) @(posedge hclk);
        an_die = en ? (16'h0001 << cfg[3:0]) : 16'h0000;
        an_lvl = en & (all | (s == {1'b0, cfg[3:0]}));
        ded_lvl = en & (cfg[3:2] == 2'b00) & (all | (s == {3'b100, cfg[1:0]}));
        lvl = cfg[7] ? ded_lvl : an_lvl;
        check("trig_level", {31'h0, trig_level}, {31'h0, lvl});
        check("dig_in_enable", {16'h0, die}, {16'h0, cfg[7] ? 16'h0000 : an_die});
        check("trig_level no ded", {31'h0, trig_level2}, {31'h0, an_lvl});
        check("dig_in_enable no ded", {16'h0, die2}, {16'h0, an_die});
    endtask

    task automatic test_trig();
        for (int c = 0; c < 16; c++) begin
            trig_case({4'h0, c[3:0]}, 1'b1, {1'b0, c[3:0]}, 1'b0);
        end
        trig_case(8'h05, 1'b1, 5'h06, 1'b0);
        trig_case(8'h05, 1'b0, 5'h05, 1'b1);
        for (int c = 0; c < 4; c++) begin
            trig_case({6'h20, c[1:0]}, 1'b1, {3'b100, c[1:0]}, 1'b0);
        end
        trig_case(8'h84, 1'b1, 5'h00, 1'b1);
        trig_case(8'h8C, 1'b1, 5'h00, 1'b1);
        trig_case(8'h85, 1'b1, 5'h05, 1'b0);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        multi_channel_mode = 1'b0;
        ext_trigger_enable = 1'b0;
        seq_start = 1'b0;
        conv_done = 1'b0;
        start_chan = 4'h0;
        src = 5'h1F;
        all_on = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_regs();
        test_wrap();
        test_trig();
        finish_test();
    end
endmodule // tb_top
